// ### hw/lsw_defines.vh
// Constants for the low-side switch diagnostic and configuration register bank.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef LSW_DEFINES_VH
`define LSW_DEFINES_VH

// ----------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------
`define LSW_FRAME_BITS 5'd16
`define LSW_CMD_BITS 5'd8

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define LSW_CMD_RD_DIAG1 8'h11
`define LSW_CMD_RD_DIAG2 8'h12
`define LSW_CMD_RD_DIAG3 8'h13
`define LSW_CMD_RD_DIAG4 8'h14
`define LSW_CMD_RD_DIAG5 8'h15
`define LSW_CMD_RD_CFG 8'h21
`define LSW_CMD_WR_CFG 8'h22
`define LSW_CMD_CLR_DIAG 8'h30

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LSW_DIAG_RST 36'hFFFFFFFFF
`define LSW_CFG_RST 8'hFF

// ----------------------------------------------------------------
// Field codes and positions
// ----------------------------------------------------------------
`define LSW_CODE_OK 2'h3
`define LSW_CODE_SCB 2'h2
`define LSW_CODE_OL 2'h1
`define LSW_CODE_SCG 2'h0
`define LSW_CFG_NOFUNC 0
`define LSW_CFG_SRC 1
`define LSW_CFG_OUT17 2
`define LSW_CFG_OUT18 3
`define LSW_CFG_OUT9 4
`define LSW_CFG_OUT10 5
`define LSW_CFG_OUT15 6
`define LSW_CFG_OUT16 7
`define LSW_D5_BATT 4
`define LSW_D5_FILL 3'h7

`endif

// ### hw/lsw_sync.v
// Two-flop level synchroniser for a bundle of asynchronous inputs.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/100ps
module lsw_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire ref_clk,
    input wire nrst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // Per-bit idle level, so release shows no false activity
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // lsw_sync

// ### hw/lsw_regs.v
// Diagnostic and configuration register bank of an 18-stage low-side switch,
// reached over a serial slave port whose clock is sampled by ref_clk.
// Assumes sclk runs well below ref_clk/4 and fault codes come from analog
// detection logic outside this clock domain.
//
// Function
// - Five diagnostic registers, read only
// - Two bits per stage, ascending, low first
// - Fifth register: stages 17, 18 in low bits
// - Codes: 11 ok, 10 short/hot, 01 open, 00 ground
// - Fifth register bit 4 shows battery sense
// - Battery bit sampled live, never latched
// - Fifth register bits 7-5 read one
// - Config read/write, resets ones, bit0 one
// - Config bit 1 picks control source
// - Config bits 2-7 pick short shutoff
// - Separate read instruction per diagnostic register
// - Clear sets fields only without present fault
// - Clear re-enables tripped stage, restarts filtering
`timescale 1ns/100ps
`include "lsw_defines.vh"
module lsw_regs #(
    parameter STAGES = 18
) (
    input wire ref_clk,
    input wire nrst,
    input wire sclk,
    input wire cs_n,
    input wire mosi,
    output reg miso,
    output reg miso_oe,
    input wire [2*STAGES-1:0] fault_code_bits_in,
    input wire battery_sense,
    output reg control_source_select,
    output reg [5:0] short_shutoff_cfg,
    output reg [STAGES-1:0] stage_shutoff,
    output reg [STAGES-1:0] current_limit,
    output reg [STAGES-1:0] filter_restart
);

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    localparam SYNC_W = 2 * STAGES + 4;
    wire [SYNC_W-1:0] sync_bus;
    wire sclk_s;
    wire cs_n_s;
    wire mosi_s;
    wire batt_s;
    wire [2*STAGES-1:0] fault_s;

    // Idle levels after reset: deselected, clock low, no fault
    // Zeros would look like a selected port and ground shorts
    lsw_sync #(
        .WIDTH(SYNC_W),
        .RST_VAL({{(2*STAGES){1'b1}}, 1'b1, 1'b0, 1'b1, 1'b0})
    ) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in({fault_code_bits_in, battery_sense, mosi, cs_n, sclk}),
        .sync_out(sync_bus)
    );

    assign sclk_s = sync_bus[0];
    assign cs_n_s = sync_bus[1];
    assign mosi_s = sync_bus[2];
    assign batt_s = sync_bus[3];
    assign fault_s = sync_bus[SYNC_W-1:4];

    // ----------------------------------------------------------------
    // Serial clock edges
    // ----------------------------------------------------------------
    reg sclk_d_r;
    wire sclk_rise;
    wire sclk_fall;

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            sclk_d_r <= 1'b0;
        else
            sclk_d_r <= sclk_s;
    end

    assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    reg [2*STAGES-1:0] diag_r;
    reg [7:0] cfg_r;
    reg [4:0] bit_cnt_r;
    reg [7:0] rx_r;
    reg [7:0] cmd_r;
    reg [7:0] tx_r;
    wire [7:0] rx_byte;
    wire cmd_done;
    wire frame_done;
    wire do_clear;
    wire do_cfg_wr;

    assign rx_byte = {rx_r[6:0], mosi_s};
    assign cmd_done = sclk_rise && (bit_cnt_r == `LSW_CMD_BITS - 5'd1);
    assign frame_done = sclk_rise && (bit_cnt_r == `LSW_FRAME_BITS - 5'd1);
    // Both take effect only on a complete frame; an aborted frame does nothing
    assign do_clear = frame_done && (cmd_r == `LSW_CMD_CLR_DIAG);
    assign do_cfg_wr = frame_done && (cmd_r == `LSW_CMD_WR_CFG);

    // ----------------------------------------------------------------
    // Register views
    // ----------------------------------------------------------------
    wire [7:0] diag_status_1;
    wire [7:0] diag_status_2;
    wire [7:0] diag_status_3;
    wire [7:0] diag_status_4;
    wire [7:0] diag_status_5;
    wire [7:0] source_and_short_config;

    assign diag_status_1 = diag_r[7:0];
    assign diag_status_2 = diag_r[15:8];
    assign diag_status_3 = diag_r[23:16];
    assign diag_status_4 = diag_r[31:24];
    // Battery bit comes straight from the synchroniser at decode time
    assign diag_status_5 = {`LSW_D5_FILL, batt_s, diag_r[35:32]};
    assign source_and_short_config = cfg_r;

    // ----------------------------------------------------------------
    // Read data selection
    // ----------------------------------------------------------------
    // Unknown instructions read zero and change nothing
    function [7:0] read_sel;
        input [7:0] cmd;
        input [7:0] d1;
        input [7:0] d2;
        input [7:0] d3;
        input [7:0] d4;
        input [7:0] d5;
        input [7:0] cfg;
        begin
            case (cmd)
                `LSW_CMD_RD_DIAG1: read_sel = d1;
                `LSW_CMD_RD_DIAG2: read_sel = d2;
                `LSW_CMD_RD_DIAG3: read_sel = d3;
                `LSW_CMD_RD_DIAG4: read_sel = d4;
                `LSW_CMD_RD_DIAG5: read_sel = d5;
                `LSW_CMD_RD_CFG: read_sel = cfg;
                default: read_sel = 8'h00;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Serial shift engine
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt_r <= 5'h00;
            rx_r <= 8'h00;
            cmd_r <= 8'h00;
            tx_r <= 8'h00;
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end
        else if (cs_n_s)
        begin
            bit_cnt_r <= 5'h00;
            cmd_r <= 8'h00;
            tx_r <= 8'h00;
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end
        else
        begin
            miso_oe <= 1'b1;
            if (sclk_rise)
            begin
                rx_r <= rx_byte;
                if (bit_cnt_r != `LSW_FRAME_BITS)
                    bit_cnt_r <= bit_cnt_r + 5'd1;
                if (cmd_done)
                begin
                    cmd_r <= rx_byte;
                    tx_r <= read_sel(rx_byte, diag_status_1, diag_status_2, diag_status_3,
                        diag_status_4, diag_status_5, source_and_short_config);
                end
            end
            if (sclk_fall && (bit_cnt_r >= `LSW_CMD_BITS) && (bit_cnt_r < `LSW_FRAME_BITS))
            begin
                // Master samples on the next rising edge
                miso <= tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration register
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            cfg_r <= `LSW_CFG_RST;
        else if (do_cfg_wr)
        begin
            cfg_r <= rx_byte;
            cfg_r[`LSW_CFG_NOFUNC] <= 1'b1;
        end
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            control_source_select <= 1'b1;
            short_shutoff_cfg <= 6'h3F;
        end
        else
        begin
            control_source_select <= cfg_r[`LSW_CFG_SRC];
            short_shutoff_cfg <= cfg_r[`LSW_CFG_OUT16:`LSW_CFG_OUT17];
        end
    end

    // ----------------------------------------------------------------
    // Per-stage shutoff selection
    // ----------------------------------------------------------------
    // Only stages 9, 10, 15..18 are configurable; the rest always shut off
    function shut_en;
        input integer idx;
        input [7:0] cfg;
        begin
            case (idx)
                8: shut_en = cfg[`LSW_CFG_OUT9];
                9: shut_en = cfg[`LSW_CFG_OUT10];
                14: shut_en = cfg[`LSW_CFG_OUT15];
                15: shut_en = cfg[`LSW_CFG_OUT16];
                16: shut_en = cfg[`LSW_CFG_OUT17];
                17: shut_en = cfg[`LSW_CFG_OUT18];
                default: shut_en = 1'b1;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Diagnostic fields and stage protection
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < STAGES; gi = gi + 1)
        begin : g_stage
            wire [1:0] code_in;
            wire fault_now;
            wire scb_now;

            assign code_in = fault_s[2*gi+1:2*gi];
            assign fault_now = (code_in != `LSW_CODE_OK);
            assign scb_now = (code_in == `LSW_CODE_SCB);

            // A present fault always wins over a clear in the same cycle
            always @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                    diag_r[2*gi+1:2*gi] <= `LSW_CODE_OK;
                else if (fault_now)
                    diag_r[2*gi+1:2*gi] <= code_in;
                else if (do_clear)
                    diag_r[2*gi+1:2*gi] <= `LSW_CODE_OK;
            end

            // Clear releases the stage; a lasting short trips it again
            always @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    stage_shutoff[gi] <= 1'b0;
                    current_limit[gi] <= 1'b0;
                    filter_restart[gi] <= 1'b0;
                end
                else
                begin
                    filter_restart[gi] <= do_clear && stage_shutoff[gi];
                    if (do_clear)
                    begin
                        stage_shutoff[gi] <= 1'b0;
                        current_limit[gi] <= 1'b0;
                    end
                    else if (scb_now)
                    begin
                        // A stage already off stays off; never off and limited at once
                        if (shut_en(gi, cfg_r))
                        begin
                            stage_shutoff[gi] <= 1'b1;
                            current_limit[gi] <= 1'b0;
                        end
                        else if (!stage_shutoff[gi])
                            current_limit[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

endmodule // lsw_regs

// ### tb/lsw_regs_asserts.sv
// Checker for the register bank: port enable, config outputs, short handling.
// Assumes binding onto lsw_regs with 18 stages.
`timescale 1ns/100ps
module lsw_regs_asserts #(
    parameter STAGES = 18
) (
    input wire ref_clk,
    input wire nrst,
    input wire cs_n,
    input wire miso_oe,
    input wire control_source_select,
    input wire [5:0] short_shutoff_cfg,
    input wire [STAGES-1:0] stage_shutoff,
    input wire [STAGES-1:0] current_limit,
    input wire [STAGES-1:0] filter_restart
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Six cycles cover the two-flop sync plus the output register
    sequence s_idle; cs_n [*6]; endsequence
    sequence s_busy; !cs_n [*6]; endsequence
    sequence s_pulse;
        (filter_restart & ~$past(stage_shutoff)) == 0 ##1 filter_restart == 0;
    endsequence
    property p_oe_off; s_idle |-> !miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe while idle");
    property p_oe_on; s_busy |-> miso_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("no oe in frame");
    property p_cfg_hold;
        cs_n [*8] |=> $stable(control_source_select) && $stable(short_shutoff_cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("cfg moved");
    property p_cfg_rst; $rose(nrst) |-> control_source_select && short_shutoff_cfg == 6'h3F;
    endproperty
    a_cfg_rst: assert property (p_cfg_rst) else $error("cfg reset");
    property p_excl; (stage_shutoff & current_limit) == 0; endproperty
    a_excl: assert property (p_excl) else $error("off and limit");
    property p_lim_mask; (current_limit & ~18'h3C300) == 0; endproperty
    a_lim_mask: assert property (p_lim_mask) else $error("limit stage");
    property p_lim_cfg; $rose(current_limit[16]) |-> !short_shutoff_cfg[0]; endproperty
    a_lim_cfg: assert property (p_lim_cfg) else $error("limit cfg");
    property p_restart; filter_restart != 0 |-> s_pulse; endproperty
    a_restart: assert property (p_restart) else $error("restart pulse");
endmodule // lsw_regs_asserts

bind lsw_regs lsw_regs_asserts #(.STAGES(STAGES)) u_chk (.ref_clk(ref_clk), .nrst(nrst),
    .cs_n(cs_n), .miso_oe(miso_oe), .control_source_select(control_source_select),
    .short_shutoff_cfg(short_shutoff_cfg), .stage_shutoff(stage_shutoff),
    .current_limit(current_limit), .filter_restart(filter_restart));

// ### tb/lsw_spi_master.sv
// Controller model: serial master, mode 0, 16-bit frames, 160 ns clock.
// Assumes xfer is called on a falling ref_clk edge.
`timescale 1ns/100ps
module lsw_spi_master (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire miso
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // One whole frame per call, one register per read
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            mosi = tx[i];
            #80 sclk = 1'b1;
            if (i < 8)
                rx[i] = miso;
            #80 sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        mosi = ~mosi; // Released: no stale level
        #80;
    endtask
endmodule // lsw_spi_master

// ### tb/tb_lsw_regs.sv
// Self-checking bench for the diagnostic and configuration register bank.
// Assumes lsw_spi_master as controller; checker bound in its own file.
`timescale 1ns/100ps
`include "lsw_defines.vh"
module tb_lsw_regs;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [35:0] fault = 36'hFFFFFFFFF;
    logic batt = 1'b1;
    wire sclk, cs_n, mosi, miso, miso_oe, src;
    wire [5:0] scfg;
    wire [17:0] shut, lim, rst_p;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] v;
    logic [17:0] rst_seen = 18'h00000;
    always #5 ref_clk = ~ref_clk;
    lsw_regs dut (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .fault_code_bits_in(fault), .battery_sense(batt),
        .control_source_select(src), .short_shutoff_cfg(scfg), .stage_shutoff(shut),
        .current_limit(lim), .filter_restart(rst_p));
    lsw_spi_master mst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    // Sticky copy of the one-cycle restart pulses
    always @(posedge ref_clk)
        rst_seen <= rst_seen | rst_p;
    task final_report;
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [35:0] seen, input logic [35:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task rd(input logic [7:0] cmd, input logic [7:0] exp);
        mst.xfer({cmd, 8'h00}, v);
        chk(v, exp);
    endtask
    task wr(input logic [7:0] cmd, input logic [7:0] data);
        mst.xfer({cmd, data}, v);
    endtask
    // Waits out the input synchronisers
    task setf(input logic [35:0] f, input logic b);
        @(negedge ref_clk);
        fault = f;
        batt = b;
        repeat (6) @(negedge ref_clk);
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            final_report;
        end
    end
    initial
    begin
        repeat (12) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (8) @(negedge ref_clk);
        for (int r = 0; r < 5; r++)
            rd(8'(`LSW_CMD_RD_DIAG1 + r), 8'hFF);
        rd(`LSW_CMD_RD_CFG, 8'hFF);
        chk({src, scfg}, 7'h7F);
        mst.xfer(16'h0500, v);
        chk(v, 8'h00);
        rd(`LSW_CMD_RD_DIAG1, 8'hFF);
        $display("reset test done");
        setf(36'hE1B1B1B1B, 1'b1);
        for (int r = 0; r < 4; r++)
            rd(8'(`LSW_CMD_RD_DIAG1 + r), 8'h1B);
        rd(`LSW_CMD_RD_DIAG5, 8'hFE);
        // Logic supply taken as up, so the battery bit is trusted
        setf(36'hE1B1B1B1B, 1'b0);
        rd(`LSW_CMD_RD_DIAG5, 8'hEE);
        setf(36'hE1B1B1B1B, 1'b1);
        rd(`LSW_CMD_RD_DIAG5, 8'hFE);
        $display("fault map test done");
        setf(36'hFFFFFFFFE, 1'b1);
        wr(`LSW_CMD_CLR_DIAG, 8'h00);
        rd(`LSW_CMD_RD_DIAG1, 8'hFE);
        rd(`LSW_CMD_RD_DIAG5, 8'hFF);
        chk(shut, 18'h00001);
        chk(rst_seen, 18'h12223);
        $display("clear test done");
        wr(`LSW_CMD_WR_CFG, 8'h00);
        rd(`LSW_CMD_RD_CFG, 8'h01);
        chk({src, scfg}, 7'h00);
        setf(36'hEFFFFFFFE, 1'b1);
        chk(lim, 18'h10000);
        chk(shut, 18'h00001);
        setf(36'hFFFFFFFFE, 1'b1);
        wr(`LSW_CMD_CLR_DIAG, 8'h00);
        chk(lim, 18'h00000);
        wr(`LSW_CMD_WR_CFG, 8'h06);
        rd(`LSW_CMD_RD_CFG, 8'h07);
        chk({src, scfg}, 7'h41);
        setf(36'hEFFFFFFFE, 1'b1);
        chk(shut, 18'h10001);
        $display("config test done");
        final_report;
    end
endmodule // tb_lsw_regs
